// [rtl/evp_pkg.sv]
/*
 Shared constants and carrier types of the vector prioritizer.
 Assumes one clock domain and a synchronous active-low reset.
*/
package evp_pkg;

   // -------------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------------
   localparam int EXC_COUNT = 60;
   localparam int IRQ_COUNT = 44;
   localparam int NUM_W     = 6;
   localparam int PRIO_W    = 3;
   localparam int KEY_W     = 4;
   localparam int VTOR_LSB  = 8;
   localparam int VTOR_MSB  = 29;

   // -------------------------------------------------------------------
   // Exception numbers and table layout
   // -------------------------------------------------------------------
   localparam logic [NUM_W-1:0] EXC_STACK_PTR = 6'h00;
   localparam logic [NUM_W-1:0] EXC_RESET     = 6'h01;
   localparam logic [NUM_W-1:0] EXC_NMI       = 6'h02;
   localparam logic [NUM_W-1:0] EXC_HARD      = 6'h03;
   localparam logic [NUM_W-1:0] EXC_MEM       = 6'h04;
   localparam logic [NUM_W-1:0] EXC_BUS       = 6'h05;
   localparam logic [NUM_W-1:0] EXC_USAGE     = 6'h06;
   localparam logic [NUM_W-1:0] EXC_SVCALL    = 6'h0b;
   localparam logic [NUM_W-1:0] EXC_DEBUG     = 6'h0c;
   localparam logic [NUM_W-1:0] EXC_PENDSV    = 6'h0e;
   localparam logic [NUM_W-1:0] EXC_SYSTICK   = 6'h0f;
   localparam logic [NUM_W-1:0] IRQ_BASE_NUM  = 6'h10;
   localparam logic [31:0]      IRQ_TABLE_OFFSET = 32'h0000_0040;
   localparam logic [31:0]      VTOR_RESET       = 32'h0000_0000;

   // Interrupt lines with a source; others never pend.
   localparam logic [IRQ_COUNT-1:0] IRQ_IMPL_MASK = 44'h081_f7fc_00bf;
   // System exceptions with programmable priority.
   localparam logic [15:0]          SYS_PROG_MASK = 16'hd870;

   // -------------------------------------------------------------------
   // Priority keys: key = fixed level + 3, so smaller is more urgent
   // -------------------------------------------------------------------
   localparam logic [PRIO_W-1:0] PRIO_RESET    = 3'h0;
   localparam logic [KEY_W-1:0]  KEY_NMI       = 4'h1;
   localparam logic [KEY_W-1:0]  KEY_HARD      = 4'h2;
   localparam logic [KEY_W-1:0]  KEY_PROG_BASE = 4'h3;
   localparam logic [KEY_W-1:0]  KEY_THREAD    = 4'hf;

   typedef struct packed {
      logic             valid;
      logic [KEY_W-1:0] key;
   } evp_cand_s;

   typedef struct packed {
      logic             valid;
      logic [KEY_W-1:0] key;
      logic [NUM_W-1:0] num;
   } evp_win_s;

   typedef struct packed {
      logic hardFault;
      logic memManage;
      logic busFault;
      logic usageFault;
      logic svCall;
      logic debugMon;
      logic pendSv;
   } evp_sysreq_s;

   typedef enum logic [1:0] {
      BOOT_STACK,
      BOOT_RESET,
      RUNNING
   } evp_boot_e;

   // Urgency key from number and programmed level.
   function automatic logic [KEY_W-1:0] keyOf(input logic [NUM_W-1:0]  num,
                                               input logic [PRIO_W-1:0] lvl);
      if (num == EXC_NMI)
         keyOf = KEY_NMI;
      else if (num == EXC_HARD)
         keyOf = KEY_HARD;
      else
         keyOf = KEY_PROG_BASE + {1'b0, lvl};
   endfunction

   // Whether an exception's priority is programmable.
   function automatic logic isProgrammable(input logic [NUM_W-1:0] num);
      if (num >= IRQ_BASE_NUM)
         isProgrammable = IRQ_IMPL_MASK[num - IRQ_BASE_NUM];
      else
         isProgrammable = SYS_PROG_MASK[num[3:0]];
   endfunction

   // Byte offset of a table entry.
   function automatic logic [31:0] vecOffset(input logic [NUM_W-1:0] num);
      if (num >= IRQ_BASE_NUM)
         vecOffset = IRQ_TABLE_OFFSET + {24'h00_0000, num - IRQ_BASE_NUM, 2'b00};
      else
         vecOffset = {24'h00_0000, num, 2'b00};
   endfunction

endpackage

// [rtl/evp_sync.sv]
/*
 Two-flip-flop synchroniser bank for asynchronous request lines.
 Assumes inputs may change at any time.
*/
`timescale 1ns/10ps
`default_nettype none
module evp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,     // System clock.
   input  wire logic             resetn,  // Synchronous reset, active low.
   input  wire logic [WIDTH-1:0] async,   // Asynchronous levels.
   output logic      [WIDTH-1:0] synced   // Levels safe for logic.
);

   // -------------------------------------------------------------------
   // Capture stages
   // -------------------------------------------------------------------
   logic [WIDTH-1:0] stage1;

   // Stage one is read only by stage two, to contain metastability.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stage1 <= '0;
         synced <= '0;
      end else begin
         stage1 <= async;
         synced <= stage1;
      end
   end

endmodule // evp_sync
`default_nettype wire

// [rtl/evp_arbiter.sv]
/*
 Combinational selector: the most urgent valid candidate, lowest index on ties.
 Assumes keys are mapped so that smaller is more urgent.
*/
`timescale 1ns/10ps
`default_nettype none
module evp_arbiter (
   input  wire evp_pkg::evp_cand_s cands [evp_pkg::EXC_COUNT], // Candidates by number.
   output evp_pkg::evp_win_s       win                         // Selected candidate.
);

   // -------------------------------------------------------------------
   // Linear scan
   // -------------------------------------------------------------------

   // An upward scan with a strict compare keeps the lowest number.
   always_comb begin
      win = '0;
      for (int i = 0; i < evp_pkg::EXC_COUNT; i++) begin
         if (cands[i].valid && (!win.valid || cands[i].key < win.key)) begin
            win.valid = 1'b1;
            win.key   = cands[i].key;
            win.num   = evp_pkg::NUM_W'(i);
         end
      end
   end

endmodule // evp_arbiter
`default_nettype wire

// [rtl/evp_prioritizer.sv]
/*
 Exception vector prioritizer: pending and active tracking, priority
 storage, table base relocation, boot fetch sequence and preemption.
 Assumes the core pulses entryAck on taking excNumber,
 returnPulse on handler completion, and answers boot fetches.
*/
`timescale 1ns/10ps
`default_nettype none
module evp_prioritizer (
   input  wire logic                   clk,            // System clock, 10 MHz.
   input  wire logic                   resetn,         // Synchronous reset, active low.
   input  wire logic [43:0]            irqLine,        // Peripheral requests, async.
   input  wire logic                   nmiLine,        // Non-maskable request, async.
   input  wire logic                   sysTickLine,    // System timer request, async.
   input  wire evp_pkg::evp_sysreq_s   sysReq,         // Core-side event pulses.
   input  wire logic                   vtorWrite,      // Offset register write strobe.
   input  wire logic [31:0]            vtorData,       // Offset register write data.
   input  wire logic                   priWrite,       // Priority write strobe.
   input  wire logic [5:0]             priNumber,      // Exception to reprogram.
   input  wire logic [2:0]             priLevel,       // New priority level.
   input  wire logic                   entryAck,       // Core took excNumber.
   input  wire logic                   returnPulse,    // Handler completed.
   input  wire logic [5:0]             returnNumber,   // Exception that completed.
   input  wire logic                   fetchAck,       // Boot fetch accepted.
   output logic                        fetchValid,     // Boot fetch requested.
   output logic      [31:0]            fetchAddr,      // Boot fetch address.
   output logic                        stackLoad,      // Boot fetch is the stack word.
   output logic                        excRequest,     // Preemption request.
   output logic      [5:0]             excNumber,      // Winning exception number.
   output logic      [31:0]            vectorAddr,     // Winning table entry address.
   output logic      [3:0]             runningKey,     // Running urgency key.
   output logic      [31:0]            vectorBase      // Current table base.
);

   // -------------------------------------------------------------------
   // Request synchronisation
   // -------------------------------------------------------------------
   localparam int ASYNC_W = evp_pkg::IRQ_COUNT + 2;

   logic [ASYNC_W-1:0] asyncIn;
   logic [ASYNC_W-1:0] asyncSync;
   logic [ASYNC_W-1:0] asyncPrev;
   logic [ASYNC_W-1:0] next_asyncPrev;
   logic [ASYNC_W-1:0] asyncRise;

   assign asyncIn = {irqLine, sysTickLine, nmiLine};

   evp_sync #(
      .WIDTH  (ASYNC_W)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .async  (asyncIn),
      .synced (asyncSync)
   );

   // Pends on a rising edge; a held level does not re-pend.
   always_comb begin
      next_asyncPrev = asyncSync;
      asyncRise      = asyncSync & ~asyncPrev;
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         asyncPrev <= '0;
      else
         asyncPrev <= next_asyncPrev;
   end

   // -------------------------------------------------------------------
   // Event map by exception number
   // -------------------------------------------------------------------
   logic [evp_pkg::EXC_COUNT-1:0] setEvent;

   // Sources land on their numbers; reserved ones stay idle.
   always_comb begin
      setEvent = '0;
      setEvent[evp_pkg::EXC_NMI]     = asyncRise[0];
      setEvent[evp_pkg::EXC_SYSTICK] = asyncRise[1];
      setEvent[evp_pkg::EXC_HARD]    = sysReq.hardFault;
      setEvent[evp_pkg::EXC_MEM]     = sysReq.memManage;
      setEvent[evp_pkg::EXC_BUS]     = sysReq.busFault;
      setEvent[evp_pkg::EXC_USAGE]   = sysReq.usageFault;
      setEvent[evp_pkg::EXC_SVCALL]  = sysReq.svCall;
      setEvent[evp_pkg::EXC_DEBUG]   = sysReq.debugMon;
      setEvent[evp_pkg::EXC_PENDSV]  = sysReq.pendSv;
      setEvent[evp_pkg::EXC_COUNT-1:16] =
         asyncRise[ASYNC_W-1:2] & evp_pkg::IRQ_IMPL_MASK;
   end

   // -------------------------------------------------------------------
   // Priority storage
   // -------------------------------------------------------------------
   // Entries 4..15 form the system handler priority register, the rest
   // the interrupt priority registers; fixed exceptions ignore writes.
   logic [evp_pkg::PRIO_W-1:0] irqPriority      [evp_pkg::EXC_COUNT];
   logic [evp_pkg::PRIO_W-1:0] next_irqPriority [evp_pkg::EXC_COUNT];

   // Three bits: levels above seven cannot be stored.
   always_comb begin
      next_irqPriority = irqPriority;
      if (priWrite && (priNumber < 6'(evp_pkg::EXC_COUNT))
          && evp_pkg::isProgrammable(priNumber))
         next_irqPriority[priNumber] = priLevel;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < evp_pkg::EXC_COUNT; i++)
            irqPriority[i] <= evp_pkg::PRIO_RESET;
      end else begin
         irqPriority <= next_irqPriority;
      end
   end

   // -------------------------------------------------------------------
   // Table base relocation
   // -------------------------------------------------------------------
   logic [31:0] vectorBaseOffsetReg;
   logic [31:0] next_vectorBaseOffsetReg;

   // Keeping bits 29:8 aligns the base to 256 bytes.
   always_comb begin
      next_vectorBaseOffsetReg = vectorBaseOffsetReg;
      if (vtorWrite) begin
         next_vectorBaseOffsetReg = '0;
         next_vectorBaseOffsetReg[evp_pkg::VTOR_MSB:evp_pkg::VTOR_LSB] =
            vtorData[evp_pkg::VTOR_MSB:evp_pkg::VTOR_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         vectorBaseOffsetReg <= evp_pkg::VTOR_RESET;
      else
         vectorBaseOffsetReg <= next_vectorBaseOffsetReg;
   end

   assign vectorBase = vectorBaseOffsetReg;

   // -------------------------------------------------------------------
   // Pending and active state
   // -------------------------------------------------------------------
   logic [evp_pkg::EXC_COUNT-1:0] pending;
   logic [evp_pkg::EXC_COUNT-1:0] next_pending;
   logic [evp_pkg::EXC_COUNT-1:0] active;
   logic [evp_pkg::EXC_COUNT-1:0] next_active;
   logic [evp_pkg::EXC_COUNT-1:0] entryClr;
   logic [evp_pkg::EXC_COUNT-1:0] returnClr;
   logic                          excValid;

   // A new event in its entry cycle is kept: set wins.
   // An equal-priority arrival stays pending.
   always_comb begin
      entryClr  = '0;
      returnClr = '0;
      if (entryAck && excValid)
         entryClr[excNumber] = 1'b1;
      if (returnPulse && (returnNumber < 6'(evp_pkg::EXC_COUNT)))
         returnClr[returnNumber] = 1'b1;
      next_pending = (pending & ~entryClr) | setEvent;
      next_active  = (active & ~returnClr) | entryClr;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pending <= '0;
         active  <= '0;
      end else begin
         pending <= next_pending;
         active  <= next_active;
      end
   end

   // -------------------------------------------------------------------
   // Candidate keys and selection
   // -------------------------------------------------------------------
   evp_pkg::evp_cand_s pendCands [evp_pkg::EXC_COUNT];
   evp_pkg::evp_cand_s actCands  [evp_pkg::EXC_COUNT];
   evp_pkg::evp_win_s  pendWin;
   evp_pkg::evp_win_s  actWin;

   // One key mapping serves both selectors,
   // so fixed levels always outrank the rest.
   generate
      for (genvar g = 0; g < evp_pkg::EXC_COUNT; g++) begin : g_cand
         logic [3:0] candKey;
         assign candKey = evp_pkg::keyOf(6'(g), irqPriority[g]);
         assign pendCands[g].valid = pending[g];
         assign pendCands[g].key   = candKey;
         assign actCands[g].valid  = active[g];
         assign actCands[g].key    = candKey;
      end
   endgenerate

   evp_arbiter u_pend_arb (
      .cands (pendCands),
      .win   (pendWin)
   );

   evp_arbiter u_act_arb (
      .cands (actCands),
      .win   (actWin)
   );

   // -------------------------------------------------------------------
   // Boot sequence
   // -------------------------------------------------------------------
   evp_pkg::evp_boot_e bootState;
   evp_pkg::evp_boot_e next_bootState;
   logic [31:0]        next_fetchAddr;

   // After reset: stack word first, then the reset entry.
   always_comb begin
      next_bootState = bootState;
      next_fetchAddr = fetchAddr;
      case (bootState)
         evp_pkg::BOOT_STACK: begin
            if (fetchAck) begin
               next_bootState = evp_pkg::BOOT_RESET;
               next_fetchAddr = vectorBaseOffsetReg +
                                evp_pkg::vecOffset(evp_pkg::EXC_RESET);
            end
         end
         evp_pkg::BOOT_RESET: begin
            if (fetchAck)
               next_bootState = evp_pkg::RUNNING;
         end
         evp_pkg::RUNNING: begin
            next_bootState = evp_pkg::RUNNING;
         end
         default: begin
            next_bootState = evp_pkg::BOOT_STACK;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         bootState <= evp_pkg::BOOT_STACK;
         fetchAddr <= evp_pkg::VTOR_RESET;
      end else begin
         bootState <= next_bootState;
         fetchAddr <= next_fetchAddr;
      end
   end

   assign fetchValid = (bootState != evp_pkg::RUNNING);
   assign stackLoad  = (bootState == evp_pkg::BOOT_STACK);

   // -------------------------------------------------------------------
   // Presented winner and preemption
   // -------------------------------------------------------------------
   logic        next_excValid;
   logic        next_excRequest;
   logic [5:0]  next_excNumber;
   logic [31:0] next_vectorAddr;
   logic [3:0]  next_runningKey;

   // Re-evaluated every cycle; outputs lag state by one clock.
   // Nothing active means thread mode, the least urgent.
   always_comb begin
      next_runningKey = actWin.valid ? actWin.key : evp_pkg::KEY_THREAD;
      next_excValid   = pendWin.valid && !(|(entryClr & ~setEvent) &&
                        (pendWin.num == excNumber));
      next_excNumber  = pendWin.num;
      next_vectorAddr = vectorBaseOffsetReg +
                        evp_pkg::vecOffset(pendWin.num);
      next_excRequest = next_excValid && (bootState == evp_pkg::RUNNING) &&
                        (pendWin.key < next_runningKey);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         excValid   <= 1'b0;
         excRequest <= 1'b0;
         excNumber  <= '0;
         vectorAddr <= evp_pkg::VTOR_RESET;
         runningKey <= evp_pkg::KEY_THREAD;
      end else begin
         excValid   <= next_excValid;
         excRequest <= next_excRequest;
         excNumber  <= next_excNumber;
         vectorAddr <= next_vectorAddr;
         runningKey <= next_runningKey;
      end
   end

endmodule // evp_prioritizer
`default_nettype wire

// [bench/evp_prioritizer_props.sv]
/* Port checker for the exception vector prioritizer.
   Assumes a bind to evp_prioritizer; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module evp_prioritizer_props (
   input wire logic        clk,         // System clock.
   input wire logic        resetn,      // Reset, active low.
   input wire logic        vtorWrite,   // Base write strobe.
   input wire logic [31:0] vtorData,    // Base write data.
   input wire logic        entryAck,    // Entry taken.
   input wire logic        returnPulse, // Handler done.
   input wire logic        fetchAck,    // Boot fetch taken.
   input wire logic        fetchValid,  // Boot fetch pending.
   input wire logic [31:0] fetchAddr,   // Boot fetch address.
   input wire logic        stackLoad,   // Stack word fetch.
   input wire logic        excRequest,  // Preemption request.
   input wire logic [5:0]  excNumber,   // Winner.
   input wire logic [31:0] vectorAddr,  // Winner entry.
   input wire logic [3:0]  runningKey,  // Running key.
   input wire logic [31:0] vectorBase   // Table base.
);
   // ------------------------------------------------------------
   // Port relations
   // ------------------------------------------------------------
   // The reset check opts out of the shared disable.
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_reset_state: assert property (disable iff (1'b0) !resetn |=> vectorBase == 32'h0
      && runningKey == 4'hf && !excRequest && fetchValid && stackLoad && fetchAddr == 32'h0)
      else $error("reset state wrong");
   a_base_write: assert property (vtorWrite |=> vectorBase == ($past(vtorData) & 32'h3fff_ff00))
      else $error("base write wrong");
   a_base_hold: assert property (!vtorWrite |=> $stable(vectorBase))
      else $error("base moved without write");
   a_boot_step: assert property (fetchValid && stackLoad && fetchAck |=> fetchValid
      && !stackLoad && fetchAddr == vectorBase + 32'h4) else $error("boot order wrong");
   a_boot_quiet: assert property (fetchValid |-> !excRequest)
      else $error("request during boot");
   a_vec_addr: assert property (excRequest && $stable(vectorBase) |->
      vectorAddr == vectorBase + {24'h0, excNumber, 2'b00}) else $error("vector address wrong");
   a_num_legal: assert property (excRequest |-> excNumber inside {[2:6], 11, 12, [14:59]})
      else $error("illegal winner");
   a_nmi_top: assert property (runningKey == 4'h1 |-> !excRequest)
      else $error("nmi preempted");
   a_key_range: assert property (runningKey inside {[1:10], 15})
      else $error("running key out of range");
   a_preempt_up: assert property (entryAck && excRequest |=> ##1
      runningKey < $past(runningKey, 2)) else $error("preemption not more urgent");
   a_return_key: assert property (returnPulse |=> ##1 runningKey >= $past(runningKey, 2))
      else $error("return raised urgency");
   a_hard_over: assert property (excRequest && excNumber == 6'h03 |-> runningKey > 4'h2)
      else $error("hard fault key wrong");
   c_boot: cover property (fetchValid && fetchAck && !stackLoad);
   c_nest: cover property (entryAck && excRequest && runningKey != 4'hf);
   c_equal: cover property (!excRequest && !fetchValid && runningKey != 4'hf);
   c_reloc: cover property (vtorWrite);
endmodule // evp_prioritizer_props
bind evp_prioritizer evp_prioritizer_props evp_prioritizer_props_inst (.clk(clk),
   .resetn(resetn), .vtorWrite(vtorWrite), .vtorData(vtorData), .entryAck(entryAck),
   .returnPulse(returnPulse), .fetchAck(fetchAck), .fetchValid(fetchValid),
   .fetchAddr(fetchAddr), .stackLoad(stackLoad), .excRequest(excRequest),
   .excNumber(excNumber), .vectorAddr(vectorAddr), .runningKey(runningKey),
   .vectorBase(vectorBase));
`default_nettype wire

// [bench/evp_core_model.sv]
/* Core-side boot fetch responder.
   Assumes fetchValid is a level; acks are one-cycle pulses. */
`timescale 1ns/10ps
`default_nettype none
module evp_core_model (
   input  wire logic       clk,        // System clock.
   input  wire logic       resetn,     // Reset, active low.
   input  wire logic       fetchValid, // Boot fetch pending.
   input  wire logic [1:0] slowAck,    // Idle cycles before each answer.
   output var  logic       fetchAck    // Fetch accepted.
);
   logic [1:0] waitLeft;
   initial fetchAck = 1'b0;
   // One-cycle pulse, so no fetch is taken twice.
   always @(negedge clk) begin
      if (!resetn || !fetchValid || fetchAck) begin
         fetchAck <= 1'b0;
         waitLeft <= slowAck;
      end else if (waitLeft != 2'h0)
         waitLeft <= waitLeft - 2'h1;
      else
         fetchAck <= 1'b1;
   end
endmodule // evp_core_model
`default_nettype wire

// [bench/tb_top.sv]
/* Self-checking bench with a behavioural priority model.
   Assumes inputs change at the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ------------------------------------------------------------
   // Stimulus, design and model state
   // ------------------------------------------------------------
   logic clk, resetn, nmiLine, sysTickLine, vtorWrite, priWrite, entryAck;
   logic returnPulse, fetchAck, fetchValid, stackLoad, excRequest;
   logic [43:0] irqLine;
   logic [31:0] vtorData, fetchAddr, vectorAddr, vectorBase, base;
   logic [5:0] priNumber, returnNumber, excNumber;
   logic [2:0] priLevel;
   logic [3:0] runningKey;
   logic [1:0] slowAck;
   logic [31:0] bv [3];
   evp_pkg::evp_sysreq_s sysReq;
   int lvl [60];
   bit pnd [60];
   int act [$];
   int seed = 32'hda01c940;
   int mismatches, n_tests;
   int pick [3] = '{15, 55, 47};
   evp_prioritizer evp_prioritizer_inst (.clk(clk), .resetn(resetn), .irqLine(irqLine),
      .nmiLine(nmiLine), .sysTickLine(sysTickLine), .sysReq(sysReq), .vtorWrite(vtorWrite),
      .vtorData(vtorData), .priWrite(priWrite), .priNumber(priNumber), .priLevel(priLevel),
      .entryAck(entryAck), .returnPulse(returnPulse), .returnNumber(returnNumber),
      .fetchAck(fetchAck), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
      .stackLoad(stackLoad), .excRequest(excRequest), .excNumber(excNumber),
      .vectorAddr(vectorAddr), .runningKey(runningKey), .vectorBase(vectorBase));
   evp_core_model evp_core_model_inst (.clk(clk), .resetn(resetn), .fetchValid(fetchValid),
      .slowAck(slowAck), .fetchAck(fetchAck));
   // Model keys: fixed level plus three.
   function automatic bit impl(int n);
      return n inside {[2:6], 11, 12, 14, 15, [16:21], 23, [34:42], [44:48], 55};
   endfunction
   function automatic int key(int n);
      return (n == 2) ? 1 : (n == 3) ? 2 : 3 + lvl[n];
   endfunction
   function automatic int win();
      int b;
      b = -1;
      for (int n = 2; n < 60; n++) if (pnd[n] && (b < 0 || key(n) < key(b))) b = n;
      return b;
   endfunction
   function automatic int rkey();
      int r;
      r = 15;
      foreach (act[i]) if (key(act[i]) < r) r = key(act[i]);
      return r;
   endfunction
   task cmp(logic [31:0] got, logic [31:0] exp, string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task chk();
      int w;
      w = win();
      cmp(32'(runningKey), rkey(), "running key");
      cmp(32'(excRequest), (w >= 0 && key(w) < rkey()), "request");
      if (w >= 0) begin
         cmp(32'(excNumber), w, "number");
         cmp(vectorAddr, base + 32'(4 * w), "vector");
      end
   endtask
   // Lines held four cycles for the synchroniser.
   task raise(int n);
      @(negedge clk);
      case (n)
         2: nmiLine <= 1'b1;
         15: sysTickLine <= 1'b1;
         3, 4, 5, 6: sysReq <= evp_pkg::evp_sysreq_s'(7'h40 >> (n - 3));
         11, 12: sysReq <= evp_pkg::evp_sysreq_s'(7'h40 >> (n - 7));
         14: sysReq <= evp_pkg::evp_sysreq_s'(7'h01);
         default: if (n >= 16) irqLine[n-16] <= 1'b1;
      endcase
      @(negedge clk) sysReq <= '0;
      repeat (3) @(negedge clk);
      {irqLine, nmiLine, sysTickLine} <= '0;
      @(negedge clk);
      if (impl(n)) pnd[n] = 1'b1;
   endtask
   task take();
      int w;
      w = win();
      @(negedge clk) entryAck <= 1'b1;
      @(negedge clk) entryAck <= 1'b0;
      pnd[w] = 1'b0;
      act.push_back(w);
      repeat (2) @(negedge clk);
   endtask
   task ret();
      @(negedge clk) returnPulse <= 1'b1;
      returnNumber <= 6'(act[$]);
      @(negedge clk) returnPulse <= 1'b0;
      void'(act.pop_back());
      repeat (2) @(negedge clk);
   endtask
   task setp(int n, int l);
      @(negedge clk) priWrite <= 1'b1;
      {priNumber, priLevel} <= {6'(n), 3'(l)};
      @(negedge clk) priWrite <= 1'b0;
      if (impl(n) && n >= 4) lvl[n] = l;
      @(negedge clk);
   endtask
   task setb(logic [31:0] d);
      @(negedge clk) vtorWrite <= 1'b1;
      vtorData <= d;
      @(negedge clk) vtorWrite <= 1'b0;
      base = d & 32'h3fff_ff00;
      @(negedge clk);
      cmp(vectorBase, base, "base");
   endtask
   // Take if more urgent pends, else return.
   task drain();
      for (int g = 0; g < 40 && (win() >= 0 || act.size() > 0); g++) begin
         if (win() >= 0 && key(win()) < rkey()) take();
         else ret();
         chk();
      end
   endtask
   task do_reset(logic [1:0] s);
      @(negedge clk) {resetn, slowAck} <= {1'b0, s};
      repeat (3) @(negedge clk);
      resetn <= 1'b1;
      foreach (lvl[i]) {lvl[i], pnd[i]} = '0;
      act.delete();
      base = 32'h0;
      @(negedge clk);
      cmp(vectorBase, 32'h0, "base");
      cmp(32'({fetchValid, stackLoad, runningKey}), 32'h3f, "boot state");
      cmp(fetchAddr, 32'h0, "stack addr");
      for (int g = 0; g < 20 && stackLoad === 1'b1; g++) @(negedge clk);
      cmp(fetchAddr, 32'h4, "entry addr");
      for (int g = 0; g < 20 && fetchValid === 1'b1; g++) @(negedge clk);
      cmp(32'(fetchValid), 32'h0, "boot end");
   endtask
   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, watchdog and tests
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Tests need under 6000 cycles; this allows 20000.
   initial begin
      #2000000;
      mismatches++;
      $display("BAD t=%0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      {resetn, nmiLine, sysTickLine, vtorWrite, priWrite, entryAck, returnPulse} = '0;
      {irqLine, vtorData, priNumber, priLevel, returnNumber, sysReq, slowAck} = '0;
      do_reset(2'h1);
      for (int n = 2; n < 60; n++) begin
         raise(n);
         chk();
         drain();
      end
      $display("test mapping done");
      bv = '{$random(seed), 32'h0000_0100, 32'h3fff_ff00};
      foreach (bv[i]) begin
         setb(bv[i]);
         raise(pick[i]);
         chk();
         drain();
      end
      $display("test relocation done");
      repeat (20) begin
         repeat (3) setp($random(seed) & 63, $random(seed) & 7);
         raise(2 + ($random(seed) & 63) % 58);
         chk();
         if (win() >= 0) take();
         repeat (2) raise(2 + ($random(seed) & 63) % 58);
         chk();
         drain();
      end
      $display("test priority done");
      setb(32'h2000_0000);
      do_reset(2'h0);
      raise(16);
      take();
      raise(17);
      chk();
      raise(3);
      chk();
      drain();
      $display("test second reset done");
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
